// File: hw/ebc_pkg.sv
// Shared constants, types and helpers for the external bus channel block
package ebc_pkg;
    localparam int NCH = 4;
    localparam logic [7:0] CTRL_STRIDE = 8'h08;
    localparam logic [7:0] CTRL_HI_OFS = 8'h04;
    localparam logic [7:0] CTRL_END = 8'h20;
    localparam logic [7:0] GCFG_OFS = 8'h40;
    localparam int SETUP_HOLD_WAIT_COUNT_LSB = 0;
    localparam int ON_BIT = 3;
    localparam int SPEED_LSB = 4;
    localparam int RDY_BIT = 6;
    localparam int STYLE_BIT = 7;
    localparam int WT_LSB = 12;
    localparam int PWT_LSB = 16;
    localparam int PM_LSB = 18;
    localparam int GCFG_BUSY_BIT = 8;
    localparam logic [31:0] CTRL_WMASK = 32'h000ff0ff;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam logic [1:0] GCFG_SPEED_RST = 2'h0;
    localparam logic [5:0] ACK_MODE_CODE = 6'h3f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {ST_IDLE, ST_ASET, ST_CSET, ST_STROBE, ST_CHOLD, ST_AHOLD} ebc_state_t;

    typedef struct packed {
        logic [1:0] ch;
        logic wr;
        logic [1:0] last_beat;
        logic [29:0] addr;
        logic [3:0] bytes;
        logic [3:0][31:0] wdata;
    } ebc_req_t;

    typedef struct packed {
        logic [29:0] addr;
        logic [3:0] ce_n;
        logic oe_n;
        logic swe_n;
        logic [3:0] bstb_n;
        logic [31:0] dout;
        logic doe;
    } ebc_pins_t;

    // Divider terminal count from a speed code
    function automatic logic [1:0] div_term(input logic [1:0] sp);
        case (sp)
            2'h0: div_term = 2'h3;
            2'h1: div_term = 2'h2;
            2'h2: div_term = 2'h1;
            default: div_term = 2'h0;
        endcase
    endfunction
endpackage

// File: hw/ebc_channel_ctrl.sv
// External bus channel configuration registers and access sequencer
// What this block does
// - Byte strobes act as byte enables when style is 0, write-only when 1.
// - Channel 0 byte-lane style loads from data strap pin 5; others reset 0.
// - Control bit 6 turns ready-input mode on or off; resets to 0.
// - Speed code 00,01,10,11 gives quarter, third, half, full bus rate.
// - Channel 0 speed loads from address straps 7:6; others reset to quarter.
// - Bit 3 enables the channel; channel 0 resets from address strap 8.
// - Set-up/hold field inserts 0 to 7 waits at each signal switch.
// - External bus clock runs at 1/1, 1/2, 1/3 or 1/4 of bus clock.
// - Each channel paces from its own divided reference clock.
// - Bursts step the word address up by one per beat.
// - Waits sit before CE fall, before strobe fall, after strobe and CE rise.
// - All-ones wait with page and ready off selects external acknowledge.
// - In ready mode wait bit 0 is dropped so the count is even.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module ebc_channel_ctrl (
    input wire logic core_clk, // Bus clock
    input wire logic rst_n, // Async reset
    input wire logic clk_en, // Freezes state when low
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic strap_data5, // Reset strap for channel 0 style
    input wire logic [2:0] strap_addr_hi, // Reset straps {on, speed[1:0]}
    input wire logic req_valid, // Access request valid
    input wire ebc_pkg::ebc_req_t req, // Access request
    output logic req_ready, // Request taken when high with valid
    output logic acc_beat, // One beat finished
    output logic [31:0] acc_rdata, // Read data of that beat
    output logic acc_done, // Access finished
    output logic acc_err, // Access refused, channel off
    input wire logic [31:0] ext_data_i, // External data in
    input wire logic ext_ack_n, // External acknowledge, low active
    input wire logic ext_ready, // External ready
    output ebc_pkg::ebc_pins_t pins, // External bus pins
    output logic ext_clk_tick // External bus clock rising edge marker
);
    import ebc_pkg::*;

    logic [31:0] ctrl_ff [NCH];
    logic [1:0] gspeed_ff;
    logic strap_pend_ff;
    logic [1:0] div_ff [NCH];
    logic [NCH-1:0] tick_v;
    logic [1:0] gdiv_ff;
    logic ext_clk_tick_ff;
    logic aw_have_ff, w_have_ff, awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
    logic [7:0] aw_addr_ff;
    logic [31:0] w_data_ff, rdata_ff;
    logic [3:0] w_strb_ff;
    logic [1:0] bresp_ff, rresp_ff;
    logic wr_commit;
    ebc_state_t st_ff;
    ebc_req_t cur_ff;
    ebc_pins_t pins_ff;
    logic [5:0] wcnt_ff;
    logic [1:0] beat_ff;
    logic ack_mode_ff, rdy_mode_ff;
    logic req_ready_ff, acc_beat_ff, acc_done_ff, acc_err_ff;
    logic [31:0] acc_rdata_ff;
    logic tick, beat_end;
    logic [31:0] cc;

    function automatic logic is_ctrl(input logic [7:0] a);
        is_ctrl = (a < CTRL_END) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] setup_hold_wait_count_of(input logic [31:0] c);
        setup_hold_wait_count_of = c[SETUP_HOLD_WAIT_COUNT_LSB +: 3];
    endfunction

    function automatic logic [5:0] wait_of(input logic [31:0] c);
        logic [5:0] raw;
        raw = {c[PWT_LSB +: 2], c[WT_LSB +: 4]};
        wait_of = c[RDY_BIT] ? {raw[5:1], 1'b0} : raw;
    endfunction

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        if (is_ctrl(a))
            rd_mux = a[2] ? 32'h0 : ctrl_ff[a[4:3]];
        else if (a == GCFG_OFS)
            rd_mux = {23'h0, st_ff != ST_IDLE, 6'h0, gspeed_ff};
        else
            rd_mux = 32'h0;
    endfunction

    // AXI write channel
    assign wr_commit = aw_have_ff && w_have_ff && !bvalid_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
            aw_addr_ff <= 8'h0;
            w_data_ff <= 32'h0;
            w_strb_ff <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && awready_ff) begin
                aw_have_ff <= 1'b1;
                awready_ff <= 1'b0;
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                w_have_ff <= 1'b1;
                wready_ff <= 1'b0;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            if (wr_commit) begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (is_ctrl(aw_addr_ff) || aw_addr_ff == GCFG_OFS) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                awready_ff <= 1'b1;
                wready_ff <= 1'b1;
            end
        end
    end

    // AXI read channel
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && arready_ff) begin
                arready_ff <= 1'b0;
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_mux(s_axi_araddr);
                rresp_ff <= (is_ctrl(s_axi_araddr) || s_axi_araddr == GCFG_OFS) ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_ff && s_axi_rready) begin
                rvalid_ff <= 1'b0;
                arready_ff <= 1'b1;
            end
        end
    end

    // Channel control registers, channel 0 strapped after reset release
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < NCH; k++)
                ctrl_ff[k] <= CTRL_RST;
            strap_pend_ff <= 1'b1;
            gspeed_ff <= GCFG_SPEED_RST;
        end else if (clk_en) begin
            if (strap_pend_ff) begin
                strap_pend_ff <= 1'b0;
                ctrl_ff[0][STYLE_BIT] <= strap_data5;
                ctrl_ff[0][SPEED_LSB +: 2] <= strap_addr_hi[1:0];
                ctrl_ff[0][ON_BIT] <= strap_addr_hi[2];
            end else if (wr_commit && is_ctrl(aw_addr_ff) && !aw_addr_ff[2]) begin
                for (int b = 0; b < 4; b++)
                    if (w_strb_ff[b])
                        ctrl_ff[aw_addr_ff[4:3]][b*8 +: 8] <= w_data_ff[b*8 +: 8] & CTRL_WMASK[b*8 +: 8];
            end else if (wr_commit && aw_addr_ff == GCFG_OFS && w_strb_ff[0]) begin
                gspeed_ff <= w_data_ff[1:0];
            end
        end
    end

    // Per-channel reference clock enables
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < NCH; k++)
                div_ff[k] <= 2'h0;
        end else if (clk_en) begin
            for (int k = 0; k < NCH; k++)
                div_ff[k] <= (div_ff[k] == 2'h0) ? div_term(ctrl_ff[k][SPEED_LSB +: 2]) : div_ff[k] - 2'h1;
        end
    end

    always_comb begin
        for (int k = 0; k < NCH; k++)
            tick_v[k] = (div_ff[k] == 2'h0);
    end

    // External bus clock divider
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gdiv_ff <= 2'h0;
            ext_clk_tick_ff <= 1'b0;
        end else if (clk_en) begin
            gdiv_ff <= (gdiv_ff == 2'h0) ? div_term(gspeed_ff) : gdiv_ff - 2'h1;
            ext_clk_tick_ff <= (gdiv_ff == 2'h0);
        end
    end

    assign cc = ctrl_ff[cur_ff.ch];
    assign tick = tick_v[cur_ff.ch];
    assign beat_end = (st_ff == ST_STROBE) && tick &&
        (ack_mode_ff ? !ext_ack_n : (wcnt_ff == 6'h0 && (!rdy_mode_ff || ext_ready)));

    // Access sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff <= ST_IDLE;
            cur_ff <= '0;
            pins_ff <= '{addr: 30'h0, ce_n: 4'hf, oe_n: 1'b1, swe_n: 1'b1, bstb_n: 4'hf, dout: 32'h0, doe: 1'b0};
            wcnt_ff <= 6'h0;
            beat_ff <= 2'h0;
            ack_mode_ff <= 1'b0;
            rdy_mode_ff <= 1'b0;
            req_ready_ff <= 1'b0;
            acc_beat_ff <= 1'b0;
            acc_done_ff <= 1'b0;
            acc_err_ff <= 1'b0;
            acc_rdata_ff <= 32'h0;
        end else if (clk_en) begin
            acc_beat_ff <= 1'b0;
            acc_done_ff <= 1'b0;
            acc_err_ff <= 1'b0;
            case (st_ff)
                ST_IDLE: begin
                    req_ready_ff <= 1'b1;
                    if (req_valid && req_ready_ff) begin
                        cur_ff <= req;
                        beat_ff <= 2'h0;
                        if (!ctrl_ff[req.ch][ON_BIT]) begin
                            acc_done_ff <= 1'b1;
                            acc_err_ff <= 1'b1;
                        end else begin
                            req_ready_ff <= 1'b0;
                            pins_ff.addr <= req.addr;
                            wcnt_ff <= {3'h0, setup_hold_wait_count_of(ctrl_ff[req.ch])};
                            ack_mode_ff <= wait_of(ctrl_ff[req.ch]) == ACK_MODE_CODE &&
                                ctrl_ff[req.ch][PM_LSB +: 2] == 2'h0 && !ctrl_ff[req.ch][RDY_BIT];
                            rdy_mode_ff <= ctrl_ff[req.ch][RDY_BIT];
                            st_ff <= ST_ASET;
                        end
                    end
                end
                ST_ASET: if (tick) begin
                    if (wcnt_ff != 6'h0) begin
                        wcnt_ff <= wcnt_ff - 6'h1;
                    end else begin
                        pins_ff.ce_n[cur_ff.ch] <= 1'b0;
                        wcnt_ff <= {3'h0, setup_hold_wait_count_of(cc)};
                        st_ff <= ST_CSET;
                    end
                end
                ST_CSET: if (tick) begin
                    if (wcnt_ff != 6'h0) begin
                        wcnt_ff <= wcnt_ff - 6'h1;
                    end else begin
                        pins_ff.oe_n <= cur_ff.wr;
                        pins_ff.swe_n <= !cur_ff.wr;
                        pins_ff.bstb_n <= (cur_ff.wr || !cc[STYLE_BIT]) ? ~cur_ff.bytes : 4'hf;
                        pins_ff.dout <= cur_ff.wdata[0];
                        pins_ff.doe <= cur_ff.wr;
                        wcnt_ff <= wait_of(cc);
                        st_ff <= ST_STROBE;
                    end
                end
                ST_STROBE: begin
                    if (beat_end) begin
                        acc_beat_ff <= 1'b1;
                        acc_rdata_ff <= ext_data_i;
                        if (beat_ff != cur_ff.last_beat) begin
                            beat_ff <= beat_ff + 2'h1;
                            pins_ff.addr <= pins_ff.addr + 30'h1;
                            pins_ff.dout <= cur_ff.wdata[beat_ff + 2'h1];
                            wcnt_ff <= wait_of(cc);
                        end else begin
                            pins_ff.oe_n <= 1'b1;
                            pins_ff.swe_n <= 1'b1;
                            pins_ff.bstb_n <= 4'hf;
                            wcnt_ff <= {3'h0, setup_hold_wait_count_of(cc)};
                            st_ff <= ST_CHOLD;
                        end
                    end else if (tick && !ack_mode_ff && wcnt_ff != 6'h0) begin
                        wcnt_ff <= wcnt_ff - 6'h1;
                    end
                end
                ST_CHOLD: if (tick) begin
                    if (wcnt_ff != 6'h0) begin
                        wcnt_ff <= wcnt_ff - 6'h1;
                    end else begin
                        pins_ff.ce_n <= 4'hf;
                        pins_ff.doe <= 1'b0;
                        wcnt_ff <= {3'h0, setup_hold_wait_count_of(cc)};
                        st_ff <= ST_AHOLD;
                    end
                end
                ST_AHOLD: if (tick) begin
                    if (wcnt_ff != 6'h0) begin
                        wcnt_ff <= wcnt_ff - 6'h1;
                    end else begin
                        acc_done_ff <= 1'b1;
                        st_ff <= ST_IDLE;
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign req_ready = req_ready_ff;
    assign acc_beat = acc_beat_ff;
    assign acc_rdata = acc_rdata_ff;
    assign acc_done = acc_done_ff;
    assign acc_err = acc_err_ff;
    assign pins = pins_ff;
    assign ext_clk_tick = ext_clk_tick_ff;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n || !clk_en);

    a_style_write_only: assert property (
        (!pins_ff.oe_n && cc[STYLE_BIT]) |-> pins_ff.bstb_n == 4'hf) else $error("strobes active on read");
    a_style_byte_en: assert property (
        (!pins_ff.oe_n && !cc[STYLE_BIT]) |-> pins_ff.bstb_n == ~cur_ff.bytes) else $error("read enables wrong");
    a_strap_load: assert property (
        $fell(strap_pend_ff) |-> ctrl_ff[0][STYLE_BIT] == $past(strap_data5) &&
        {ctrl_ff[0][ON_BIT], ctrl_ff[0][SPEED_LSB +: 2]} == $past(strap_addr_hi))
        else $error("strap not loaded");
    a_ready_bit_write: assert property (
        (wr_commit && is_ctrl(aw_addr_ff) && !aw_addr_ff[2] && w_strb_ff[0] && !strap_pend_ff) |=>
        ctrl_ff[$past(aw_addr_ff[4:3])][RDY_BIT] == $past(w_data_ff[RDY_BIT]))
        else $error("ready bit not written");
    a_quarter_speed: assert property (
        (!strap_pend_ff && tick_v[1] && ctrl_ff[1][SPEED_LSB +: 2] == 2'h0) |=> !tick_v[1] [*3] ##1 tick_v[1])
        else $error("quarter rate wrong");
    a_ext_clk_third: assert property (
        (ext_clk_tick_ff && gdiv_ff == 2'h2 && gspeed_ff == 2'h1) |=> !ext_clk_tick_ff [*2] ##1 ext_clk_tick_ff)
        else $error("third rate wrong");
    a_setup_load: assert property (
        (st_ff == ST_IDLE ##1 st_ff == ST_ASET) |-> wcnt_ff == {3'h0, setup_hold_wait_count_of(cc)}) else $error("setup count wrong");
    a_burst_addr_step: assert property (
        (beat_end && beat_ff != cur_ff.last_beat) |=> pins_ff.addr == $past(pins_ff.addr) + 30'h1)
        else $error("burst address not stepped");
    a_ack_wait: assert property (
        (st_ff == ST_STROBE && ack_mode_ff && ext_ack_n) |=> st_ff == ST_STROBE && !acc_beat_ff)
        else $error("ack mode did not wait");
    a_ready_even: assert property (
        (st_ff == ST_CSET ##1 st_ff == ST_STROBE && rdy_mode_ff) |-> !wcnt_ff[0]) else $error("odd ready wait");
    a_off_no_access: assert property (
        (st_ff == ST_IDLE && req_valid && req_ready_ff && !ctrl_ff[req.ch][ON_BIT]) |=>
        acc_err_ff && pins_ff.ce_n == 4'hf && st_ff == ST_IDLE) else $error("disabled channel accessed");

    c_burst_read: cover property (acc_done_ff && !cur_ff.wr && cur_ff.last_beat == 2'h3);
    c_single_write: cover property (acc_done_ff && cur_ff.wr && cur_ff.last_beat == 2'h0);
    c_ack_stall: cover property (st_ff == ST_STROBE && ack_mode_ff && ext_ack_n);
    c_refused: cover property (acc_err_ff);
endmodule

// File: test/ebc_ext_mem.sv
// External memory model answering the bus channel pins
`timescale 1ns/1ps
module ebc_ext_mem (
    input wire logic core_clk, // Bus clock
    input wire ebc_pkg::ebc_pins_t pins, // Pins from the controller
    input wire logic [3:0] ack_dly, // Strobe cycles before ack and ready
    output logic [31:0] ext_data_i, // Read data to the controller
    output logic ext_ack_n, // Acknowledge, low active
    output logic ext_ready // Ready, high active
);
    import ebc_pkg::*;
    logic [31:0] mem [256];
    logic [31:0] junk = 32'h5a5a5a5a;
    logic [3:0] scnt = 4'h0;
    logic strb;
    initial for (int i = 0; i < 256; i++) mem[i] = 32'hc0de0000 | i;
    assign strb = !pins.oe_n || !pins.swe_n;
    // Released data bus shows a changing pattern, never stale data
    assign ext_data_i = pins.oe_n ? junk : mem[pins.addr[7:0]];
    assign ext_ack_n = !(strb && scnt >= ack_dly);
    assign ext_ready = strb && scnt >= ack_dly;
    always @(posedge core_clk) begin
        junk <= ~junk;
        scnt <= strb ? scnt + 4'h1 : 4'h0;
        for (int i = 0; i < 4; i++)
            if (pins.doe && !pins.swe_n && !pins.bstb_n[i]) mem[pins.addr[7:0]][i*8 +: 8] <= pins.dout[i*8 +: 8];
    end
endmodule

// File: test/tb_ext_bus_channel_timing_cfg.sv
// Self-checking bench for the external bus channel block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
    $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module tb_ext_bus_channel_timing_cfg;
    import ebc_pkg::*;
    logic core_clk = 1'h0, rst_n = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, req_valid = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, ext_data_i, s_axi_rdata, acc_rdata;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_ready, acc_beat;
    logic acc_done, acc_err, ext_ack_n, ext_ready, ext_clk_tick, err, ce_any;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    ebc_req_t req = '0;
    ebc_pins_t pins;
    logic [3:0] ack_dly = 4'h0, bseen;
    logic [3:0][31:0] wd = '0, keep;
    logic [31:0] rd [4];
    int fails = 0, n_tests = 0, cec = 0, ce_len = 0, stc = 0, st_len = 0, tg = 0, tper = 0, l1;

    ebc_channel_ctrl ebc_channel_ctrl_i (.core_clk, .rst_n, .clk_en(1'h1), .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .strap_data5(1'h1), .strap_addr_hi(3'h6), .req_valid,
        .req, .req_ready, .acc_beat, .acc_rdata, .acc_done, .acc_err, .ext_data_i, .ext_ack_n, .ext_ready,
        .pins, .ext_clk_tick);
    ebc_ext_mem ebc_ext_mem_i (.core_clk, .pins, .ack_dly, .ext_data_i, .ext_ack_n, .ext_ready);

    always #50 core_clk = ~core_clk;

    // Lengths of chip-enable and strobe pulses, external clock spacing
    always @(posedge core_clk) begin
        if (pins.ce_n !== 4'hf) begin
            cec++;
            ce_any = 1'h1;
        end else if (cec != 0) begin
            ce_len = cec;
            cec = 0;
        end
        if (!pins.oe_n || !pins.swe_n) begin
            stc++;
            bseen = pins.bstb_n;
        end else if (stc != 0) begin
            st_len = stc;
            stc = 0;
        end
        if (ext_clk_tick === 1'h1) begin
            tper = tg;
            tg = 1;
        end else tg++;
    end

    function automatic logic [31:0] cf(input logic [1:0] sp, input logic [2:0] s, input logic [3:0] wt,
        input logic [1:0] page_wait_count, input logic rdy, input logic sty);
        cf = (32'h1 << ON_BIT) | (32'(sp) << SPEED_LSB) | (32'(s) << SETUP_HOLD_WAIT_COUNT_LSB) | (32'(rdy) << RDY_BIT);
        cf = cf | (32'(sty) << STYLE_BIT) | (32'(wt) << WT_LSB) | (32'(page_wait_count) << PWT_LSB);
    endfunction

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int g;
        begin
            g = 0;
            @(posedge core_clk);
            s_axi_awaddr <= a;
            s_axi_awvalid <= 1'h1;
            s_axi_wdata <= d;
            s_axi_wvalid <= 1'h1;
            s_axi_bready <= 1'h1;
            forever begin
                @(posedge core_clk);
                if (s_axi_awvalid && s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
                if (s_axi_wvalid && s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
                if (s_axi_bvalid === 1'h1) begin
                    s_axi_bready <= 1'h0;
                    `CHK("bresp", er, s_axi_bresp)
                    break;
                end
                if (++g > 200) begin fails++; break; end
            end
        end
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int g;
        begin
            g = 0;
            @(posedge core_clk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'h1;
            s_axi_rready <= 1'h1;
            forever begin
                @(posedge core_clk);
                if (s_axi_arvalid && s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
                if (s_axi_rvalid === 1'h1) begin
                    s_axi_rready <= 1'h0;
                    `CHK("rdata", e, s_axi_rdata)
                    `CHK("rresp", er, s_axi_rresp)
                    break;
                end
                if (++g > 200) begin fails++; break; end
            end
        end
    endtask

    task automatic acc(input logic [1:0] ch, input logic wr, input logic [1:0] lb, input logic [29:0] a,
        input logic [3:0] by);
        int g;
        int nb;
        begin
            g = 0;
            nb = 0;
            bseen = 4'hf;
            ce_any = 1'h0;
            @(posedge core_clk);
            req_valid <= 1'h1;
            req <= '{ch: ch, wr: wr, last_beat: lb, addr: a, bytes: by, wdata: wd};
            forever begin
                @(posedge core_clk);
                if (req_valid && req_ready === 1'h1) req_valid <= 1'h0;
                if (acc_beat === 1'h1 && nb < 4) begin rd[nb] = acc_rdata; nb++; end
                if (acc_done === 1'h1) begin err = acc_err; break; end
                if (++g > 3000) begin fails++; break; end
            end
        end
    endtask

    task automatic end_of_test;
        begin
            $display("compares %0d mismatches %0d", n_tests, fails);
            if (fails == 0 && n_tests > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask

    initial begin
        repeat (50000) @(posedge core_clk);
        fails++;
        end_of_test;
    end

    initial begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'h1;
        repeat (3) @(posedge core_clk);
        axr(8'h00, 32'h000000a8, RESP_OKAY);
        axr(8'h08, 32'h0, RESP_OKAY);
        axr(8'h18, 32'h0, RESP_OKAY);
        axr(GCFG_OFS, 32'h0, RESP_OKAY);
        axw(8'h18, 32'hfff3ffff, RESP_OKAY);
        axr(8'h18, 32'h0003f0ff, RESP_OKAY);
        axw(8'h18, 32'h0, RESP_OKAY);
        axr(8'h18, 32'h0, RESP_OKAY);
        axw(8'h44, 32'h1, RESP_SLVERR);
        axr(8'h44, 32'h0, RESP_SLVERR);
        axr(8'h1c, 32'h0, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            axw(GCFG_OFS, 32'(i), RESP_OKAY);
            repeat (12) @(posedge core_clk);
            `CHK("ext_clk_period", 4 - i, tper)
        end
        for (int s = 0; s < 4; s++) begin
            axw(8'h00, cf(2'(s), 3'h0, 4'h0, 2'h0, 1'h0, 1'h0), RESP_OKAY);
            acc(2'h0, 1'h0, 2'h0, 30'h10, 4'h5);
            `CHK("ce_low_cycles", 3 * (4 - s), ce_len)
            `CHK("lane_strobes", 4'ha, bseen)
        end
        for (int s = 1; s < 8; s += 6) begin
            axw(8'h00, cf(2'h3, 3'(s), 4'h0, 2'h0, 1'h0, 1'h0), RESP_OKAY);
            acc(2'h0, 1'h0, 2'h0, 30'h10, 4'hf);
            `CHK("ce_low_cycles", 2 * s + 3, ce_len)
        end
        axw(8'h00, cf(2'h3, 3'h0, 4'h0, 2'h0, 1'h0, 1'h1), RESP_OKAY);
        acc(2'h0, 1'h0, 2'h0, 30'h30, 4'h3);
        `CHK("read_lane_strobes", 4'hf, bseen)
        acc(2'h0, 1'h1, 2'h0, 30'h30, 4'h3);
        `CHK("write_lane_strobes", 4'hc, bseen)
        axw(8'h00, cf(2'h3, 3'h0, 4'h1, 2'h0, 1'h0, 1'h0), RESP_OKAY);
        keep = {32'h44444444, 32'h33333333, 32'h22222222, 32'h11111111};
        wd = keep;
        acc(2'h0, 1'h1, 2'h3, 30'h80, 4'hf);
        wd = '0;
        acc(2'h0, 1'h0, 2'h3, 30'h80, 4'hf);
        for (int i = 0; i < 4; i++) `CHK("burst_readback", keep[i], rd[i])
        acc(2'h0, 1'h0, 2'h3, 30'h90, 4'hf);
        for (int i = 0; i < 4; i++) `CHK("burst_word", 32'hc0de0090 + i, rd[i])
        axw(8'h00, cf(2'h3, 3'h0, 4'h3, 2'h0, 1'h1, 1'h0), RESP_OKAY);
        acc(2'h0, 1'h0, 2'h0, 30'h10, 4'hf);
        `CHK("ready_strobe_cycles", 3, st_len)
        axw(8'h00, cf(2'h3, 3'h0, 4'h3, 2'h0, 1'h0, 1'h0), RESP_OKAY);
        acc(2'h0, 1'h0, 2'h0, 30'h10, 4'hf);
        `CHK("wait_strobe_cycles", 4, st_len)
        axw(8'h00, cf(2'h3, 3'h0, 4'hf, 2'h3, 1'h0, 1'h0), RESP_OKAY);
        ack_dly <= 4'h2;
        acc(2'h0, 1'h0, 2'h0, 30'h10, 4'hf);
        l1 = st_len;
        ack_dly <= 4'h6;
        acc(2'h0, 1'h0, 2'h0, 30'h10, 4'hf);
        `CHK("ack_stretch", 4, st_len - l1)
        acc(2'h1, 1'h0, 2'h0, 30'h10, 4'hf);
        `CHK("off_refused", 1'h1, err)
        `CHK("off_ce_quiet", 1'h0, ce_any)
        axw(8'h08, cf(2'h3, 3'h0, 4'h0, 2'h0, 1'h0, 1'h0), RESP_OKAY);
        acc(2'h1, 1'h0, 2'h0, 30'h10, 4'hf);
        `CHK("on_accepted", 1'h0, err)
        end_of_test;
    end
endmodule
